// File: common/pbs_pkg.sv
// Shared constants, types and helpers of the pipelined burst RAM port
package pbs_pkg;

  // ****************************************
  // Array shape
  // ****************************************
  localparam int ADDR_W = 18;
  localparam int LANES = 4;
  localparam int LANES_X18 = 2;
  localparam int LANE_DATA_W = 8;
  localparam int LANE_W = 9;

  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam int AV_ADDR_W = 4;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam int CTRL_NARROW_BIT = 0;
  localparam logic CTRL_NARROW_RESET = 1'b0;
  localparam int STAT_OE_BIT = 0;
  localparam int STAT_CNT_LSB = 1;
  localparam int STAT_ACTIVE_BIT = 3;
  localparam int STAT_WRITE_BIT = 4;
  localparam int STAT_S1_BIT = 5;
  localparam int STAT_S2_BIT = 6;

  // ****************************************
  // Commands and burst states
  // ****************************************
  typedef enum logic [2:0] {
    CMD_SUSPEND,
    CMD_LOAD_READ,
    CMD_LOAD_WRITE,
    CMD_BURST,
    CMD_DESELECT,
    CMD_NOOP
  } pbs_cmd_e;

  typedef enum logic [1:0] {
    BST_IDLE,
    BST_READ,
    BST_WRITE
  } pbs_burst_e;

  // Low two address bits of burst step k
  function automatic logic [1:0] pbs_burst_low(
    input logic [1:0] base,
    input logic [1:0] k,
    input logic interleave
  );
    pbs_burst_low = interleave ? (base ^ k) : 2'(base + k);
  endfunction : pbs_burst_low

endpackage : pbs_pkg

// File: hw/pbs_cell_array.sv
// Flip-flop storage array with per-lane write enables
`timescale 1ns/1ns
module pbs_cell_array import pbs_pkg::*; #(
  parameter int AW = ADDR_W,
  parameter int NL = LANES,
  parameter int LW = LANE_W
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [NL-1:0] lane_we,
  input wire logic [AW-1:0] wr_index,
  input wire logic [NL*LW-1:0] wr_word,
  input wire logic [AW-1:0] rd_index,
  output logic [NL*LW-1:0] rd_word
);

  // ****************************************
  // Storage
  // ****************************************
  // Plain unpacked array: a packed struct this size would choke simulators
  logic [NL*LW-1:0] cells [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      for (int i = 0; i < NL; i++) begin
        if (lane_we[i]) begin
          cells[wr_index][i*LW +: LW] <= wr_word[i*LW +: LW];
        end
      end
    end
  end

  assign rd_word = cells[rd_index];

endmodule : pbs_cell_array

// File: hw/pbs_port.sv
// Command decode, burst counter and data pipeline of the burst RAM port
//
// Overview of operation
// - Gate input high at an edge: no burst or pipeline state advances that edge; the register bus still does.
// - Suspended edge holds the burst and pipeline registers and the data pins' state; register-bus registers still update.
// - Selected only with both low selects low and high select high.
// - Load/advance low while unselected and gate low is a deselect.
// - Data bus floats two cycles after deselect; pipeline still drains.
// - Load/advance high in a burst bumps the 2-bit counter, internal address.
// - Read/write input is ignored while the counter advances.
// - Burst direction is fixed by read/write at the load cycle.
// - Each low byte strobe enables one 9-bit lane of a write.
// - Any mix of strobes writes those lanes, others unchanged.
// - Narrow mode: lanes 3 and 4 never written.
// - Burst order high: addresses are base xor 0,1,2,3.
// - Burst order low: addresses are base plus 0,1,2,3 mod 4.
// - Data outputs float from power-up until the first read.
// - After the fourth address the counter wraps and repeats.
// - Read data out, or write data in, two cycles after load.
// - Sleep request suspends edges like gate high, data retained; the register bus still updates.
`timescale 1ns/1ns
module pbs_port import pbs_pkg::*; #(
  parameter int AW = ADDR_W,
  parameter int NL = LANES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cycle_gate_n,
  input wire logic select_low_a,
  input wire logic select_low_b,
  input wire logic select_high,
  input wire logic advance_or_load,
  input wire logic read_not_write,
  input wire logic [AW-1:0] address,
  input wire logic [NL-1:0] byte_lane_write_n,
  input wire logic burst_order_select,
  input wire logic sleep_request,
  input wire logic [NL*LANE_DATA_W-1:0] dq_in,
  output logic [NL*LANE_DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [NL-1:0] parity_lane_bits_in,
  output logic [NL-1:0] parity_lane_bits_out,
  output logic parity_lane_bits_oe,
  input wire logic [AV_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  localparam int WW = NL * LANE_W;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    pbs_burst_e burst;
    logic [AW-1:0] base;
    logic [1:0] cnt;
    logic s1_valid;
    logic s1_write;
    logic [AW-1:0] s1_addr;
    logic [NL-1:0] s1_bw_n;
    logic s2_valid;
    logic s2_write;
    logic [AW-1:0] s2_addr;
    logic [NL-1:0] s2_bw_n;
    logic oe;
    logic [WW-1:0] dout;
    logic narrow;
    logic av_ack;
    logic [31:0] av_rdata;
  } pbs_port_s;

  pbs_port_s st;
  pbs_port_s next_st;
  pbs_cmd_e cmd;
  logic go;
  logic selected;
  logic mem_we;
  logic [NL-1:0] lane_we;
  logic [NL-1:0] lane_mask;
  logic [WW-1:0] wr_word;
  logic [WW-1:0] rd_word;
  logic av_req;

  assign go = !cycle_gate_n && !sleep_request;
  assign selected = !select_low_a && !select_low_b && select_high;
  assign av_req = avs_read || avs_write;

  // ****************************************
  // Storage
  // ****************************************
  pbs_cell_array #(.AW(AW), .NL(NL), .LW(LANE_W)) u_cells (
    .clk(clk),
    .we(mem_we),
    .lane_we(lane_we),
    .wr_index(st.s2_addr),
    .wr_word(wr_word),
    .rd_index(st.s2_addr),
    .rd_word(rd_word)
  );

  // ****************************************
  // Lane packing
  // ****************************************
  always_comb begin
    for (int i = 0; i < NL; i++) begin
      wr_word[i*LANE_W +: LANE_W] =
        {parity_lane_bits_in[i], dq_in[i*LANE_DATA_W +: LANE_DATA_W]};
      dq_out[i*LANE_DATA_W +: LANE_DATA_W] =
        st.dout[i*LANE_W +: LANE_DATA_W];
      parity_lane_bits_out[i] = st.dout[i*LANE_W + LANE_DATA_W];
      lane_mask[i] = !(st.narrow && (i >= LANES_X18));
    end
  end

  assign dq_oe = st.oe;
  assign parity_lane_bits_oe = st.oe;
  assign avs_readdata = st.av_rdata;
  assign avs_waitrequest = av_req && !st.av_ack;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    mem_we = 1'b0;
    lane_we = '0;
    if (!go) begin
      cmd = CMD_SUSPEND;
    end else if (!advance_or_load) begin
      if (!selected) begin
        cmd = CMD_DESELECT;
      end else if (read_not_write) begin
        cmd = CMD_LOAD_READ;
      end else begin
        cmd = CMD_LOAD_WRITE;
      end
    end else if (st.burst == BST_IDLE) begin
      cmd = CMD_NOOP;
    end else begin
      cmd = CMD_BURST;
    end

    // Pipeline drains on every live edge, whatever the new command is
    if (cmd != CMD_SUSPEND) begin
      next_st.s2_valid = st.s1_valid;
      next_st.s2_write = st.s1_write;
      next_st.s2_addr = st.s1_addr;
      next_st.s2_bw_n = st.s1_bw_n;
      next_st.oe = st.s2_valid && !st.s2_write;
      if (st.s2_valid && !st.s2_write) begin
        next_st.dout = rd_word;
      end
      mem_we = st.s2_valid && st.s2_write;
      lane_we = ~st.s2_bw_n & lane_mask;
    end

    case (cmd)
      CMD_LOAD_READ, CMD_LOAD_WRITE: begin
        next_st.burst = (cmd == CMD_LOAD_READ) ? BST_READ : BST_WRITE;
        next_st.base = address;
        next_st.cnt = 2'h0;
        next_st.s1_valid = 1'b1;
        next_st.s1_write = (cmd == CMD_LOAD_WRITE);
        next_st.s1_addr = address;
        next_st.s1_bw_n = byte_lane_write_n;
      end
      CMD_BURST: begin
        // Wraps past step 3 by plain 2-bit overflow
        next_st.cnt = 2'(st.cnt + 2'h1);
        next_st.s1_valid = 1'b1;
        next_st.s1_write = (st.burst == BST_WRITE);
        next_st.s1_addr = {st.base[AW-1:2],
          pbs_burst_low(st.base[1:0], next_st.cnt,
                        burst_order_select)};
        next_st.s1_bw_n = byte_lane_write_n;
      end
      CMD_DESELECT: begin
        next_st.burst = BST_IDLE;
        next_st.s1_valid = 1'b0;
      end
      CMD_NOOP: begin
        next_st.s1_valid = 1'b0;
      end
      default: begin
      end
    endcase

    // Register bus: one wait cycle, then the answer
    next_st.av_ack = av_req && !st.av_ack;
    if (avs_read && !st.av_ack) begin
      next_st.av_rdata = 32'h0;
      if (avs_address == CTRL_OFS) begin
        next_st.av_rdata[CTRL_NARROW_BIT] = st.narrow;
      end else if (avs_address == STAT_OFS) begin
        next_st.av_rdata[STAT_OE_BIT] = st.oe;
        next_st.av_rdata[STAT_CNT_LSB +: 2] = st.cnt;
        next_st.av_rdata[STAT_ACTIVE_BIT] = (st.burst != BST_IDLE);
        next_st.av_rdata[STAT_WRITE_BIT] = (st.burst == BST_WRITE);
        next_st.av_rdata[STAT_S1_BIT] = st.s1_valid;
        next_st.av_rdata[STAT_S2_BIT] = st.s2_valid;
      end
    end
    if (avs_write && st.av_ack && avs_byteenable[0] &&
        avs_address == CTRL_OFS) begin
      next_st.narrow = avs_writedata[CTRL_NARROW_BIT];
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // The device pins have no reset; rst stands in for power-up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.burst <= BST_IDLE;
      st.narrow <= CTRL_NARROW_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_suspend_holds: assert property (
    @(posedge clk) disable iff (rst)
    !go |=> (st.s1_valid == $past(st.s1_valid)) &&
      (st.cnt == $past(st.cnt)) && (st.s2_addr == $past(st.s2_addr)))
    else $error("pipeline moved on a suspended edge");

  a_suspend_pins: assert property (
    @(posedge clk) disable iff (rst)
    !go |=> $stable(dq_oe) && $stable(dq_out))
    else $error("data pins changed on a suspended edge");

  a_deselect_no_load: assert property (
    @(posedge clk) disable iff (rst)
    go && !advance_or_load && (select_low_a || select_low_b ||
      !select_high) |=> !st.s1_valid && st.burst == BST_IDLE)
    else $error("unselected load started an access");

  a_deselect_float: assert property (
    @(posedge clk) disable iff (rst)
    (go && !advance_or_load && !selected) ##1 go ##1 go |=> !dq_oe)
    else $error("bus not floating two cycles after deselect");

  a_read_latency: assert property (
    @(posedge clk) disable iff (rst)
    (go && !advance_or_load && selected && read_not_write) ##1 go ##1 go
      |=> dq_oe && parity_lane_bits_oe)
    else $error("read data not driven two cycles after load");

  a_write_latency: assert property (
    @(posedge clk) disable iff (rst)
    (go && !advance_or_load && selected && !read_not_write) ##1 go ##1 go
      |-> mem_we ##1 !dq_oe)
    else $error("write not performed two cycles after load");

  a_counter_step: assert property (
    @(posedge clk) disable iff (rst)
    go && advance_or_load && st.burst != BST_IDLE
      |=> st.cnt == 2'($past(st.cnt) + 2'h1) && st.s1_valid)
    else $error("burst counter did not advance");

  a_counter_wrap: assert property (
    @(posedge clk) disable iff (rst)
    go && advance_or_load && st.burst != BST_IDLE && st.cnt == 2'h3
      |=> st.cnt == 2'h0 && st.s1_addr[1:0] == st.base[1:0])
    else $error("burst counter did not wrap to start");

  a_burst_dir: assert property (
    @(posedge clk) disable iff (rst)
    go && advance_or_load && st.burst != BST_IDLE
      |=> $stable(st.burst) && st.s1_write == (st.burst == BST_WRITE))
    else $error("burst direction changed mid burst");

  a_interleave_addr: assert property (
    @(posedge clk) disable iff (rst)
    go && advance_or_load && st.burst != BST_IDLE && burst_order_select
      |=> st.s1_addr[1:0] == (st.base[1:0] ^ st.cnt))
    else $error("interleaved burst address wrong");

  a_linear_addr: assert property (
    @(posedge clk) disable iff (rst)
    go && advance_or_load && st.burst != BST_IDLE && !burst_order_select
      |=> st.s1_addr[1:0] == 2'(st.base[1:0] + st.cnt))
    else $error("linear burst address wrong");

  a_narrow_lanes: assert property (
    @(posedge clk) disable iff (rst)
    mem_we && st.narrow |-> lane_we[NL-1:LANES_X18] == '0)
    else $error("upper lanes written in narrow mode");

  a_noop_idle: assert property (
    @(posedge clk) disable iff (rst)
    go && advance_or_load && st.burst == BST_IDLE
      |=> !st.s1_valid && $stable(st.cnt))
    else $error("no-op cycle started an access");

endmodule : pbs_port

// File: tb/pbs_ctrl_model.sv
// Far-side memory controller model for the burst RAM port
`timescale 1ns/1ns
module pbs_ctrl_model import pbs_pkg::*; (
  input wire logic clk,
  output logic cycle_gate_n,
  output logic sleep_request,
  output logic select_low_a,
  output logic select_low_b,
  output logic select_high,
  output logic advance_or_load,
  output logic read_not_write,
  output logic [ADDR_W-1:0] address,
  output logic [LANES-1:0] byte_lane_write_n,
  output logic [31:0] dq_in,
  output logic [LANES-1:0] parity_lane_bits_in
);
  // ****************
  // Write data pipe
  // ****************
  logic [35:0] d1 = '0;
  logic [35:0] d2 = '0;
  logic [35:0] noise = 36'h5a5a5a5a5;
  logic w1 = 1'b0;
  logic w2 = 1'b0;
  logic open = 1'b0;
  logic wr = 1'b0;
  initial begin
    {cycle_gate_n, sleep_request, select_low_a, select_low_b} = '0;
    {select_high, advance_or_load, read_not_write, address} = '0;
    byte_lane_write_n = '1;
  end
  // Released bus toggles so stale data never looks valid
  assign {parity_lane_bits_in, dq_in} = w2 ? d2 : noise;
  always @(posedge clk) begin
    noise <= ~noise;
    if (!cycle_gate_n && !sleep_request) begin
      if (!advance_or_load) begin
        open = {select_low_a, select_low_b, select_high} == 3'b001;
        wr = !read_not_write;
      end
      w1 <= open && wr;
      w2 <= w1;
      d1 <= 36'({$urandom, $urandom});
      d2 <= d1;
    end
  end
  task automatic cmd(input logic [1:0] g, input logic [2:0] s,
      input logic a, input logic rw, input logic [ADDR_W-1:0] ad,
      input logic [3:0] bw);
    @(posedge clk);
    {sleep_request, cycle_gate_n} <= g;
    {select_low_a, select_low_b, select_high} <= s;
    advance_or_load <= a;
    read_not_write <= rw;
    address <= ad;
    byte_lane_write_n <= bw;
  endtask : cmd
endmodule : pbs_ctrl_model

// File: tb/pipelined_burst_sram_port_tb.sv
// Self-checking bench of the burst RAM port
`timescale 1ns/1ns
module pipelined_burst_sram_port_tb;
  import pbs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic order = 1'b0;
  logic gn, sa, sb, sh, adv, rnw, slp, oe, poe, wtq;
  logic [ADDR_W-1:0] addr;
  logic [3:0] bwn, pin, pout;
  logic [31:0] din, dout, rd;
  logic [3:0] aaddr = '0;
  logic aread = 1'b0;
  logic awrite = 1'b0;
  logic [31:0] wdata = '0;
  int failures = 0;
  int n_compared = 0;
  pbs_port i_dut (.clk(clk), .rst(rst), .cycle_gate_n(gn),
    .select_low_a(sa), .select_low_b(sb), .select_high(sh),
    .advance_or_load(adv), .read_not_write(rnw), .address(addr),
    .byte_lane_write_n(bwn), .burst_order_select(order),
    .sleep_request(slp), .dq_in(din), .dq_out(dout), .dq_oe(oe),
    .parity_lane_bits_in(pin), .parity_lane_bits_out(pout),
    .parity_lane_bits_oe(poe), .avs_address(aaddr), .avs_read(aread),
    .avs_write(awrite), .avs_writedata(wdata), .avs_byteenable(4'h1),
    .avs_readdata(rd), .avs_waitrequest(wtq));
  pbs_ctrl_model i_ctrl (.clk(clk), .cycle_gate_n(gn),
    .sleep_request(slp), .select_low_a(sa), .select_low_b(sb),
    .select_high(sh), .advance_or_load(adv), .read_not_write(rnw),
    .address(addr), .byte_lane_write_n(bwn), .dq_in(din),
    .parity_lane_bits_in(pin));
  initial forever #25 clk = ~clk;
  // ****************
  // Reference model
  // ****************
  logic [35:0] mem [16];
  logic [35:0] edq;
  logic s1v, s1w, s2v, s2w, open, bwr, eoe, narrow;
  logic [ADDR_W-1:0] s1a, s2a, base;
  logic [3:0] s1b, s2b;
  logic [1:0] k;
  function automatic logic [1:0] step(input logic [1:0] b, k);
    return order ? b ^ k : b + k;
  endfunction : step
  function automatic logic [35:0] msk(input logic [3:0] bw);
    msk = '0;
    for (int i = 0; i < 4; i++) begin
      if (!bw[i] && !(narrow && i > 1)) begin
        msk[8*i+:8] = 8'hff;
        msk[32+i] = 1'b1;
      end
    end
  endfunction : msk
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {s1v, s2v, open, eoe} = '0;
    end else if (!gn && !slp) begin
      if (s2v && s2w) begin
        mem[s2a[3:0]] = (mem[s2a[3:0]] & ~msk(s2b)) | ({pin, din} & msk(s2b));
      end
      eoe = s2v && !s2w;
      edq = mem[s2a[3:0]];
      {s2v, s2w, s2a, s2b} = {s1v, s1w, s1a, s1b};
      if (!adv) begin
        open = !sa && !sb && sh;
        k = '0;
        base = addr;
        bwr = !rnw;
      end else begin
        k = k + 2'b01;
      end
      s1v = open;
      s1w = bwr;
      s1b = bwn;
      s1a = {base[ADDR_W-1:2], step(base[1:0], k)};
    end
  end
  always @(negedge clk) begin
    chk("dq_oe", 36'(oe), 36'(eoe));
    chk("parity_oe", 36'(poe), 36'(eoe));
    if (eoe) chk("read_data", {pout, dout}, edq);
  end
  // ****************
  // Tasks
  // ****************
  task automatic chk(input string nm, input logic [35:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic av(input logic w, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    aaddr <= a;
    awrite <= w;
    aread <= !w;
    wdata <= d;
    do begin
      @(posedge clk);
    end while (wtq !== 1'b0);
    q = rd;
    aread <= 1'b0;
    awrite <= 1'b0;
  endtask : av
  task automatic burst(input logic rw, input int n);
    logic [31:0] r;
    i_ctrl.cmd('0, 3'b001, 1'b0, rw, ADDR_W'($urandom % 16), 4'($urandom));
    repeat (n) begin
      r = $urandom;
      i_ctrl.cmd({r[0] & r[1], r[2] & r[3]}, r[6:4], 1'b1, r[7],
        ADDR_W'(r[11:8]), r[15:12]);
    end
  endtask : burst
  task automatic rnd(input int n);
    logic [31:0] r;
    repeat (n) begin
      r = $urandom;
      i_ctrl.cmd({r[0] & r[1] & r[2], r[3] & r[4] & r[5]},
        (r[6] & r[7]) ? r[10:8] : 3'b001, r[11], r[12],
        ADDR_W'(r[16:13]), r[20:17]);
    end
  endtask : rnd
  task automatic idle();
    i_ctrl.cmd('0, 3'b000, 1'b0, 1'b0, '0, 4'hf);
    repeat (3) i_ctrl.cmd('0, 3'b000, 1'b1, 1'b0, '0, 4'hf);
  endtask : idle
  task automatic end_sim();
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // ****************
  // Main sequence
  // ****************
  initial begin
    logic [31:0] q;
    logic [2:0] nsel [3];
    nsel = '{3'b101, 3'b011, 3'b000};
    q = $urandom(15588);
    narrow = 1'b0;
    for (int o = 0; o < 2; o++) begin
      rst <= 1'b1;
      order <= o[0];
      narrow = CTRL_NARROW_RESET;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      av(1'b0, CTRL_OFS, '0, q);
      chk("ctrl_reset", 36'(q), 36'(CTRL_NARROW_RESET));
      // Back-to-back full writes give every word a known value
      for (int a = 0; a < 16; a++) begin
        i_ctrl.cmd('0, 3'b001, 1'b0, 1'b0, ADDR_W'(a), 4'h0);
      end
      for (int i = 0; i < 3; i++) begin
        burst(1'b0, 5);
        burst(1'b1, 7);
        i_ctrl.cmd('0, nsel[i], 1'b0, 1'b1, '0, 4'h0);
        i_ctrl.cmd('0, 3'b001, 1'b1, 1'b0, '0, 4'h0);
      end
      idle();
      av(1'b0, STAT_OFS, '0, q);
      chk("status_idle", 36'(q & 32'h79), '0);
      av(1'b1, CTRL_OFS, 32'h1, q);
      av(1'b0, CTRL_OFS, '0, q);
      chk("ctrl_narrow", 36'(q), 36'h1);
      narrow = 1'b1;
      rnd(150);
      idle();
      av(1'b1, CTRL_OFS, '0, q);
      narrow = 1'b0;
      av(1'b0, 4'h8, '0, q);
      chk("unmapped", 36'(q), '0);
      rnd(200);
      idle();
    end
    end_sim();
  end
  initial begin
    #(50 * 5000);
    failures++;
    end_sim();
  end
endmodule : pipelined_burst_sram_port_tb
